// [ofs_supervisor.sv]
// Purpose: Fault supervision and start-up sequencing for one output channel
// Assumes: Comparators and enable arrive asynchronously; settings come as plain ports
// Notes: Codes share one telemetry scale for voltage and temperature

`timescale 1ns/1ps
module ofs_supervisor
  import ofs_pkg::*;
#(
  parameter int unsigned RAMP_CYC = 400000,
  parameter int unsigned ON_DELAY_CYC = 40000,
  parameter int unsigned RETRY_BASE_CYC = RETRY_MIN_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic enable_pin,
  input wire logic ov_cmp,
  input wire logic [11:0] target_code,
  input wire ofs_cfg_type cfg_in,
  input wire logic cfg_load,
  input wire ofs_tlm_type tlm,
  input wire logic [2:0] tlm_sel,
  input wire logic tlm_req,
  input wire logic fault_clear,
  input wire logic [7:0] pred_id_in,
  input wire logic [7:0] succ_id_in,
  input wire logic seq_id_load,
  input wire logic pred_done,
  input wire logic store_all,
  input wire logic restore_req,
  input wire logic restore_level,
  input wire logic [1:0] level_open,
  input wire logic group_fault_bus_in,
  input wire logic switch_tick,
  output logic group_fault_bus_out,
  output logic group_fault_bus_oe,
  output logic driver_en,
  output logic power_good,
  output logic [11:0] momentary_target,
  output logic [11:0] tlm_data,
  output logic tlm_valid,
  output ofs_tlm_type snap_data,
  output ofs_fault_type snap_status,
  output logic [3:0] phase_a,
  output logic [3:0] phase_b,
  output logic seq_done,
  output logic [7:0] pred_id,
  output logic [7:0] succ_id,
  output ofs_fault_type fault_status
);
  initial begin
    if (RAMP_CYC < 1 || ON_DELAY_CYC < 1 || RETRY_BASE_CYC < 1) $error("Counts must be positive");
  end

  typedef enum logic [5:0] {
    S_OFF = 6'h01, S_DELAY = 6'h02, S_RAMP = 6'h04, S_ON = 6'h08, S_FAULT = 6'h10, S_WAIT = 6'h20
  } ofs_state_type;

  // Synchronised asynchronous inputs
  logic [2:0] sync_q;
  ofs_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d({enable_pin, ov_cmp, group_fault_bus_in}),
    .q(sync_q)
  );
  logic en_s, ovc_s, grp_s;
  assign en_s = sync_q[2];
  assign ovc_s = sync_q[1];
  assign grp_s = sync_q[0];

  // Settings store
  ofs_cfg_type nvm_cfg;
  logic nvm_valid;
  ofs_cfg_type cfg_r, cfg_nxt;
  ofs_nvm #(.LEVELS(2)) u_nvm (
    .core_clk(core_clk),
    .nrst(nrst),
    .live_cfg(cfg_r),
    .store_all(store_all),
    .restore_req(restore_req),
    .restore_level(restore_level),
    .level_open(level_open),
    .load_cfg(nvm_cfg),
    .load_valid(nvm_valid),
    .user_present()
  );

  // Configuration and sequencing identities
  logic [7:0] pred_r, pred_nxt, succ_r, succ_nxt;
  always_comb begin
    cfg_nxt = cfg_r;
    pred_nxt = pred_r;
    succ_nxt = succ_r;
    if (nvm_valid) cfg_nxt = nvm_cfg;
    else if (cfg_load) cfg_nxt = cfg_in;
    if (seq_id_load) begin
      pred_nxt = pred_id_in;
      succ_nxt = succ_id_in;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= '{ov_override: 1'b0, ov_limit: 12'h000, ov_retry: 1'b0, ot_fault_limit: OT_FAULT_DEF,
                 ot_warn_limit: OT_WARN_DEF, ot_retry: 1'b0, retry_sel: 2'h0, interleave: 4'h0,
                 group_tx_en: 1'b0, group_follow: 1'b0};
      pred_r <= 8'h00;
      succ_r <= 8'h00;
    end else begin
      cfg_r <= cfg_nxt;
      pred_r <= pred_nxt;
      succ_r <= succ_nxt;
    end
  end

  // Thresholds
  logic [11:0] ov_lim;
  logic [13:0] def_lim;
  logic ov_now, ot_now, below_warn;
  assign def_lim = 14'(target_code) + 14'((19'(target_code) * 19'(OV_PCT)) / 19'd100);
  assign ov_lim = cfg_r.ov_override ? cfg_r.ov_limit : (def_lim > 14'h0fff ? 12'hfff : def_lim[11:0]);
  assign ov_now = ovc_s || (tlm.vout > ov_lim);
  assign ot_now = tlm.temp > cfg_r.ot_fault_limit;
  assign below_warn = tlm.temp < cfg_r.ot_warn_limit;

  // Main sequencer
  ofs_state_type st_r, st_nxt;
  ofs_fault_type flt_r, flt_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [11:0] tgt_r, tgt_nxt, pre_r, pre_nxt;
  logic pg_r, pg_nxt, drv_r, drv_nxt, bus_r, bus_nxt, done_r, done_nxt;
  logic snap_take;
  logic [31:0] retry_cyc;
  logic retry_ok;
  assign retry_cyc = RETRY_BASE_CYC * (32'd1 << cfg_r.retry_sel);
  assign retry_ok = !cfg_r.group_tx_en && ((flt_r.ov && cfg_r.ov_retry) || (flt_r.ot && cfg_r.ot_retry)) &&
                    !flt_r.group;

  always_comb begin
    st_nxt = st_r;
    flt_nxt = flt_r;
    cnt_nxt = cnt_r;
    tgt_nxt = tgt_r;
    pre_nxt = pre_r;
    pg_nxt = pg_r;
    drv_nxt = drv_r;
    bus_nxt = 1'b0;
    done_nxt = done_r;
    snap_take = 1'b0;
    if (fault_clear) flt_nxt = '0;
    case (st_r)
      S_OFF: begin
        done_nxt = 1'b0;
        if (en_s && pred_done) begin
          st_nxt = S_DELAY;
          cnt_nxt = 32'(ON_DELAY_CYC);
        end
      end
      S_DELAY: begin
        if (!en_s) st_nxt = S_OFF;
        else if (cnt_r > 32'd1) cnt_nxt = cnt_r - 32'd1;
        else begin
          pre_nxt = tlm.vout;
          if (tlm.vout > ov_lim) begin
            flt_nxt.ov = 1'b1;
            st_nxt = S_FAULT;
          end else begin
            tgt_nxt = tlm.vout;
            drv_nxt = 1'b1;
            cnt_nxt = 32'(RAMP_CYC);
            st_nxt = S_RAMP;
          end
        end
      end
      S_RAMP, S_ON: begin
        if (st_r == S_RAMP) begin
          // Linear step keeps the ramp time fixed whatever the start
          tgt_nxt = 12'((32'(target_code) * (32'(RAMP_CYC) - cnt_r + 32'd1) + 32'(pre_r) * (cnt_r - 32'd1))
                    / 32'(RAMP_CYC));
          if (cnt_r > 32'd1) cnt_nxt = cnt_r - 32'd1;
          else begin
            tgt_nxt = target_code;
            pg_nxt = 1'b1;
            done_nxt = 1'b1;
            st_nxt = S_ON;
          end
        end
        if (!en_s) begin
          st_nxt = S_OFF;
          drv_nxt = 1'b0;
          pg_nxt = 1'b0;
        end
        if (ov_now || ot_now || (grp_s && cfg_r.group_follow)) begin
          flt_nxt.ov = flt_r.ov | ov_now;
          flt_nxt.ot = flt_r.ot | ot_now;
          flt_nxt.group = flt_r.group | (grp_s && cfg_r.group_follow);
          bus_nxt = cfg_r.group_tx_en && (ov_now || ot_now);
          st_nxt = S_FAULT;
          drv_nxt = 1'b0;
          pg_nxt = 1'b0;
        end
      end
      S_FAULT: begin
        drv_nxt = 1'b0;
        pg_nxt = 1'b0;
        done_nxt = 1'b0;
        snap_take = 1'b1;
        cnt_nxt = retry_cyc;
        st_nxt = retry_ok ? S_WAIT : S_OFF;
      end
      S_WAIT: begin
        if (cnt_r > 32'd1) cnt_nxt = cnt_r - 32'd1;
        else if (flt_r.ot && !below_warn) cnt_nxt = retry_cyc;
        else begin
          flt_nxt = '0;
          st_nxt = S_OFF;
        end
        if (!en_s) st_nxt = S_OFF;
      end
      default: st_nxt = S_OFF;
    endcase
    // Hold off start while a fault latch stays set
    if (st_r == S_OFF && (flt_r.ov || flt_r.ot || flt_r.group) && !fault_clear) st_nxt = S_OFF;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= S_OFF;
      flt_r <= '0;
      cnt_r <= 32'd0;
      tgt_r <= 12'h000;
      pre_r <= 12'h000;
      pg_r <= 1'b0;
      drv_r <= 1'b0;
      bus_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      flt_r <= flt_nxt;
      cnt_r <= cnt_nxt;
      tgt_r <= tgt_nxt;
      pre_r <= pre_nxt;
      pg_r <= pg_nxt;
      drv_r <= drv_nxt;
      bus_r <= bus_nxt;
      done_r <= done_nxt;
    end
  end

  // Telemetry, snapshot and phase
  logic [11:0] td_r, td_nxt;
  logic tv_r, tv_nxt;
  ofs_tlm_type snap_r, snap_nxt;
  ofs_fault_type snaps_r, snaps_nxt;
  logic [3:0] ph_r, ph_nxt, phb_r, phb_nxt;
  always_comb begin
    td_nxt = td_r;
    tv_nxt = tlm_req;
    snap_nxt = snap_r;
    snaps_nxt = snaps_r;
    ph_nxt = ph_r;
    phb_nxt = phb_r;
    if (tlm_req) begin
      case (tlm_sel)
        TLM_VIN: td_nxt = tlm.vin;
        TLM_VOUT: td_nxt = tlm.vout;
        TLM_IOUT: td_nxt = tlm.iout;
        TLM_TEMP: td_nxt = tlm.temp;
        TLM_DUTY: td_nxt = tlm.duty;
        TLM_FREQ: td_nxt = tlm.freq;
        TLM_AUX: td_nxt = tlm.aux;
        default: td_nxt = 12'h000;
      endcase
    end
    if (snap_take) begin
      snap_nxt = tlm;
      snaps_nxt = flt_r;
    end
    if (switch_tick) ph_nxt = cfg_r.interleave;
    if (switch_tick) phb_nxt = cfg_r.interleave + HALF_TURN;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      td_r <= 12'h000;
      tv_r <= 1'b0;
      snap_r <= '0;
      snaps_r <= '0;
      ph_r <= 4'h0;
      phb_r <= HALF_TURN;
    end else begin
      td_r <= td_nxt;
      tv_r <= tv_nxt;
      snap_r <= snap_nxt;
      snaps_r <= snaps_nxt;
      ph_r <= ph_nxt;
      phb_r <= phb_nxt;
    end
  end

  assign group_fault_bus_out = 1'b0;
  assign group_fault_bus_oe = bus_r;
  assign driver_en = drv_r;
  assign power_good = pg_r;
  assign momentary_target = tgt_r;
  assign tlm_data = td_r;
  assign tlm_valid = tv_r;
  assign snap_data = snap_r;
  assign snap_status = snaps_r;
  assign phase_a = ph_r;
  assign phase_b = phb_r;
  assign seq_done = done_r;
  assign pred_id = pred_r;
  assign succ_id = succ_r;
  assign fault_status = flt_r;

  a_ov_shutdown: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_ON && ov_now) |=> (st_r == S_FAULT && !drv_r)) else $error("No shutdown on overvoltage");
  a_ot_shutdown: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_ON && ot_now) |=> flt_r.ot) else $error("No latch on overtemperature");
  a_no_retry_def: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_FAULT && !cfg_r.ov_retry && !cfg_r.ot_retry) |=> st_r == S_OFF) else $error("Retried");
  a_group_noretry: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_FAULT && cfg_r.group_tx_en) |=> st_r != S_WAIT) else $error("Retry with broadcast");
  a_phase_half: assert property (@(posedge core_clk) disable iff (!nrst)
    phase_b == 4'(phase_a + HALF_TURN)) else $error("Phase gap lost");
  a_pg_after_ramp: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_RAMP && cnt_r == 32'd1 && en_s && !ov_now && !ot_now && !grp_s) |=> pg_r) else $error("No power good");
  a_prebias_ov: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_DELAY && cnt_r <= 32'd1 && en_s && tlm.vout > ov_lim) |=> (flt_r.ov && !drv_r)) else $error("Prebias OV");
  a_snap_take: assert property (@(posedge core_clk) disable iff (!nrst)
    (st_r == S_FAULT) |=> snaps_r == $past(flt_r)) else $error("Snapshot missing");
endmodule : ofs_supervisor

// [ofs_pkg.sv]
// Purpose: Shared constants and carriers for the output fault supervisor
// Assumes: 40 MHz core clock, 12-bit telemetry codes
// Notes: Thresholds are codes in the telemetry scale

package ofs_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned RETRY_MIN_MS = 35;
  localparam int unsigned RETRY_MAX_MS = 280;
  localparam int unsigned RETRY_MIN_CYC = RETRY_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_MAX_CYC = RETRY_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned OV_PCT = 15;
  localparam logic [11:0] OT_FAULT_DEF = 12'h073; // 115 C
  localparam logic [11:0] OT_WARN_DEF = 12'h069;  // 105 C
  localparam int unsigned PHASE_STEPS = 16;       // 22.5 deg each
  localparam logic [3:0] HALF_TURN = 4'h8;        // 180 deg
  localparam logic [2:0] TLM_VIN = 3'h0;
  localparam logic [2:0] TLM_VOUT = 3'h1;
  localparam logic [2:0] TLM_IOUT = 3'h2;
  localparam logic [2:0] TLM_TEMP = 3'h3;
  localparam logic [2:0] TLM_DUTY = 3'h4;
  localparam logic [2:0] TLM_FREQ = 3'h5;
  localparam logic [2:0] TLM_AUX = 3'h6;

  typedef struct packed {
    logic [11:0] vin;
    logic [11:0] vout;
    logic [11:0] iout;
    logic [11:0] temp;
    logic [11:0] duty;
    logic [11:0] freq;
    logic [11:0] aux;
  } ofs_tlm_type;

  typedef struct packed {
    logic ov_override;
    logic [11:0] ov_limit;
    logic ov_retry;
    logic [11:0] ot_fault_limit;
    logic [11:0] ot_warn_limit;
    logic ot_retry;
    logic [1:0] retry_sel;
    logic [3:0] interleave;
    logic group_tx_en;
    logic group_follow;
  } ofs_cfg_type;

  typedef struct packed {
    logic ov;
    logic ot;
    logic group;
  } ofs_fault_type;
endpackage : ofs_pkg

// [ofs_sync.sv]
// Purpose: Two-flop synchroniser for asynchronous levels
// Assumes: Inputs come from comparators or pins
// Notes: First stage feeds only the second

`timescale 1ns/1ps
module ofs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // Two flops in series
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
  assign q = q_r;
endmodule : ofs_sync

// [ofs_nvm.sv]
// Purpose: Settings store with user and factory images
// Assumes: Single-cycle array writes
// Notes: Restore allowed only to levels opened to the user

`timescale 1ns/1ps
module ofs_nvm
  import ofs_pkg::*;
#(
  parameter int unsigned LEVELS = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire ofs_cfg_type live_cfg,
  input wire logic store_all,
  input wire logic restore_req,
  input wire logic [$clog2(LEVELS)-1:0] restore_level,
  input wire logic [LEVELS-1:0] level_open,
  output ofs_cfg_type load_cfg,
  output logic load_valid,
  output logic user_present
);
  initial begin
    if (LEVELS < 2) $error("LEVELS must be at least 2");
  end

  ofs_cfg_type mem_r [LEVELS];
  // Image-present flags are part of the nonvolatile store, so reset leaves them alone
  logic [LEVELS-1:0] valid_r = {{(LEVELS-1){1'b0}}, 1'b1};
  logic [LEVELS-1:0] valid_nxt;
  logic boot_r, boot_nxt;
  ofs_cfg_type load_r, load_nxt;
  logic lv_r, lv_nxt;

  // Load at init from user image if stored, restore only open levels
  always_comb begin
    valid_nxt = valid_r;
    boot_nxt = 1'b0;
    load_nxt = load_r;
    lv_nxt = 1'b0;
    if (store_all) begin
      valid_nxt[1] = 1'b1;
    end
    if (boot_r && valid_r[1]) begin
      load_nxt = mem_r[1];
      lv_nxt = 1'b1;
    end else if (restore_req && level_open[restore_level] && valid_r[restore_level]) begin
      load_nxt = mem_r[restore_level];
      lv_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      boot_r <= 1'b1;
      load_r <= '0;
      lv_r <= 1'b0;
    end else begin
      boot_r <= boot_nxt;
      load_r <= load_nxt;
      lv_r <= lv_nxt;
    end
  end

  // Array storage: level 0 factory, level 1 user
  always_ff @(posedge core_clk) begin
    valid_r <= valid_nxt;
    if (store_all) begin
      mem_r[1] <= live_cfg;
    end
    mem_r[0] <= '{ov_override: 1'b0, ov_limit: 12'h000, ov_retry: 1'b0, ot_fault_limit: OT_FAULT_DEF,
                  ot_warn_limit: OT_WARN_DEF, ot_retry: 1'b0, retry_sel: 2'h0, interleave: 4'h0,
                  group_tx_en: 1'b0, group_follow: 1'b0};
  end

  assign load_cfg = load_r;
  assign load_valid = lv_r;
  assign user_present = valid_r[1];
endmodule : ofs_nvm

// [ofs_peer_model.sv]
// Purpose: Peer power module sharing the open-drain group fault line
// Assumes: The line has a pull-up, so any party pulling low marks a fault
// Notes: The peer broadcasts on request and latches a follow-on shutdown

`timescale 1ns/1ps
module ofs_peer_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic dut_oe,
  input wire logic peer_fault,
  output logic follow_shut_r,
  output logic line_level
);
  logic peer_oe_r;

  // Wired line: pull-up unless some party pulls low
  assign line_level = ~(dut_oe | peer_oe_r);

  // Peer drives its own fault and follows a fault seen on the line
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      peer_oe_r <= 1'b0;
      follow_shut_r <= 1'b0;
    end else begin
      peer_oe_r <= peer_fault;
      if (!line_level && !peer_oe_r) begin
        follow_shut_r <= 1'b1;
      end
    end
  end
endmodule : ofs_peer_model

// [ofs_supervisor_tb.sv]
// Purpose: Self-checking bench for the output fault supervisor
// Assumes: Short counts for ramp, turn-on delay and retry base
// Notes: Outputs are read just after a rising edge, showing the prior cycle

`timescale 1ns/1ps
module ofs_supervisor_tb;
  import ofs_pkg::*;
  localparam int RAMP = 20;
  localparam int ONDLY = 10;
  localparam int RBASE = 30;
  localparam int P_TLM = 0, P_TICK = 1, P_SEQ = 2, P_CLR = 3, P_STORE = 4, P_RESTORE = 5;
  logic core_clk, nrst, enable_pin, ov_cmp, cfg_load, tlm_req, fault_clear, seq_id_load, pred_done;
  logic store_all, restore_req, restore_level, switch_tick, peer_fault, peer_shut, line_level;
  logic group_fault_bus_in, group_fault_bus_oe, driver_en, power_good, tlm_valid, seq_done;
  logic [11:0] target_code, momentary_target, tlm_data;
  logic [2:0] tlm_sel;
  logic [7:0] pred_id_in, succ_id_in, pred_id, succ_id;
  logic [1:0] level_open;
  logic [3:0] phase_a, phase_b;
  ofs_cfg_type cfg_in, cfg_v;
  ofs_tlm_type tlm, snap_data;
  ofs_fault_type snap_status, fault_status;
  logic [11:0] pb [3];
  int n_mismatch, n_checks, n;

  // Design input reads high while the shared line is pulled low
  assign group_fault_bus_in = ~line_level;

  ofs_supervisor #(.RAMP_CYC(RAMP), .ON_DELAY_CYC(ONDLY), .RETRY_BASE_CYC(RBASE)) ofs_supervisor_inst (
    .core_clk, .nrst, .enable_pin, .ov_cmp, .target_code, .cfg_in, .cfg_load, .tlm, .tlm_sel, .tlm_req,
    .fault_clear, .pred_id_in, .succ_id_in, .seq_id_load, .pred_done, .store_all, .restore_req,
    .restore_level, .level_open, .group_fault_bus_in, .switch_tick, .group_fault_bus_out(),
    .group_fault_bus_oe, .driver_en, .power_good, .momentary_target, .tlm_data, .tlm_valid, .snap_data,
    .snap_status, .phase_a, .phase_b, .seq_done, .pred_id, .succ_id, .fault_status
  );
  ofs_peer_model ofs_peer_model_inst (
    .core_clk, .nrst, .dut_oe(group_fault_bus_oe), .peer_fault, .follow_shut_r(peer_shut), .line_level
  );

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task automatic chk_code(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t code %h expected %h", $time, got, exp);
    end
  endtask : chk_code

  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] %0t count %0d outside %0d to %0d", $time, got, lo, hi);
    end
  endtask : chk_range

  // Bounded wait: 0 drivers, 1 power good, 2 target reached
  task automatic wait_for(input int sel, input logic val, input int bound, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit && k < bound) begin
      cyc(1);
      k++;
      case (sel)
        0: hit = (driver_en === val);
        1: hit = (power_good === val);
        default: hit = ((momentary_target === target_code) === val);
      endcase
    end
    if (!hit) begin
      n_mismatch++;
      $display("[FAIL] %0t wait %0d timed out", $time, sel);
      tally_and_finish();
    end
  endtask : wait_for

  // Reset with quiet inputs; outputs must be low while held
  task automatic do_reset;
    nrst <= 1'b0;
    enable_pin <= 1'b0;
    ov_cmp <= 1'b0;
    pred_done <= 1'b1;
    peer_fault <= 1'b0;
    tlm.vout <= 12'h000;
    tlm.temp <= 12'h040;
    cyc(8);
    chk_bit(driver_en | power_good | group_fault_bus_oe, 1'b0);
    nrst <= 1'b1;
    cyc(2);
  endtask : do_reset

  task automatic set_cfg(input ofs_cfg_type c);
    cfg_in <= c;
    cfg_load <= 1'b1;
    cyc(1);
    cfg_load <= 1'b0;
    cyc(1);
  endtask : set_cfg

  // Strobe the selected input high for one edge, then hold it low for two
  task automatic pulse(input int sel);
    for (int v = 1; v >= 0; v--) begin
      case (sel)
        P_TLM: tlm_req <= 1'(v);
        P_TICK: switch_tick <= 1'(v);
        P_SEQ: seq_id_load <= 1'(v);
        P_CLR: fault_clear <= 1'(v);
        P_STORE: store_all <= 1'(v);
        default: restore_req <= 1'(v);
      endcase
      cyc(1);
    end
    cyc(1);
  endtask : pulse

  task automatic power_on;
    enable_pin <= 1'b1;
    wait_for(0, 1'b1, ONDLY + 8, n);
  endtask : power_on

  function automatic ofs_cfg_type mk_cfg(input logic ovr, input logic otr, input logic tx, input logic fol,
                                         input logic [3:0] il, input logic [1:0] rs);
    ofs_cfg_type c;
    c = '0;
    c.ot_fault_limit = OT_FAULT_DEF;
    c.ot_warn_limit = OT_WARN_DEF;
    c.ov_retry = ovr;
    c.ot_retry = otr;
    c.group_tx_en = tx;
    c.group_follow = fol;
    c.interleave = il;
    c.retry_sel = rs;
    return c;
  endfunction : mk_cfg

  // Main sequence
  initial begin
    {nrst, enable_pin, ov_cmp, cfg_load, tlm_req, fault_clear, seq_id_load} = '0;
    {store_all, restore_req, restore_level, switch_tick, peer_fault} = '0;
    pred_done = 1'b1;
    target_code = 12'h100;
    tlm_sel = 3'h0;
    pred_id_in = 8'h00;
    succ_id_in = 8'h00;
    level_open = 2'b11;
    cfg_in = '0;
    tlm = {12'h0c0, 12'h000, 12'h031, 12'h040, 12'h055, 12'h066, 12'h077};
    pb = '{12'h000, 12'h080, 12'h110};
    n_mismatch = 0;
    n_checks = 0;
    do_reset();
    // Each of the seven telemetry selectors returns its live reading; the unused code 7 returns zero
    for (int i = 0; i < 7; i++) begin
      tlm_sel <= 3'(i);
      pulse(P_TLM);
    end
    for (int i = 0; i < 8; i++) begin
      tlm_sel <= 3'(i);
      tlm_req <= 1'b1;
      cyc(1);
      tlm_req <= 1'b0;
      cyc(1);
      chk_bit(tlm_valid, 1'b1);
      chk_code(tlm_data, (i < 7) ? tlm[83 - 12 * (i % 7) -: 12] : 12'h000);
      cyc(1);
      chk_bit(tlm_valid, 1'b0);
    end
    // Phase offsets and the fixed half-turn between channels
    for (int p = 0; p < PHASE_STEPS; p += 5) begin
      set_cfg(mk_cfg(1'b0, 1'b0, 1'b0, 1'b0, 4'(p), 2'h0));
      pulse(P_TICK);
      chk_code({8'h00, phase_a}, 12'(p));
      chk_code({8'h00, phase_b}, {8'h00, 4'(p) + HALF_TURN});
    end
    pred_id_in <= 8'h3a;
    succ_id_in <= 8'hc5;
    pulse(P_SEQ);
    chk_code({4'h0, pred_id}, 12'h03a);
    chk_code({4'h0, succ_id}, 12'h0c5);
    // Prebias below, at zero and above target, within the limit
    foreach (pb[k]) begin
      do_reset();
      pred_done <= 1'b0;
      tlm.vout <= pb[k];
      enable_pin <= 1'b1;
      cyc(40);
      chk_bit(driver_en, 1'b0);
      pred_done <= 1'b1;
      wait_for(0, 1'b1, ONDLY + 8, n);
      chk_code(momentary_target, pb[k]);
      // Halfway through the ramp the target sits midway between start and setpoint
      cyc(RAMP / 2);
      chk_code(momentary_target, 12'((32'(target_code) + 32'(pb[k])) / 32'd2));
      wait_for(1, 1'b1, RAMP + 8, n);
      chk_range(n, RAMP - RAMP / 2, RAMP - RAMP / 2);
      wait_for(2, 1'b1, RAMP + 4, n);
      chk_bit(seq_done, 1'b1);
      enable_pin <= 1'b0;
      wait_for(1, 1'b0, 6, n);
    end
    // Prebias over the default limit, then under a programmed limit
    for (int o = 0; o < 2; o++) begin
      do_reset();
      cfg_v = mk_cfg(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0);
      cfg_v.ov_override = (o == 1);
      cfg_v.ov_limit = 12'h180;
      set_cfg(cfg_v);
      tlm.vout <= 12'h140;
      enable_pin <= 1'b1;
      cyc(ONDLY + RAMP + 10);
      chk_bit(power_good, o == 1);
      chk_bit(fault_status.ov, o == 0);
    end
    // Overvoltage in regulation: latch, retry, broadcast without retry
    for (int m = 0; m < 3; m++) begin
      do_reset();
      set_cfg(mk_cfg(m > 0, 1'b0, m == 2, 1'b0, 4'h0, 2'h1));
      power_on();
      wait_for(1, 1'b1, RAMP + 8, n);
      ov_cmp <= 1'b1;
      wait_for(0, 1'b0, 5, n);
      // The broadcast stands for the cycle in which the drivers drop
      chk_bit(group_fault_bus_oe, m == 2);
      ov_cmp <= 1'b0;
      cyc(4);
      chk_bit(fault_status.ov, 1'b1);
      chk_bit(snap_status.ov, 1'b1);
      chk_code(snap_data.iout, 12'h031);
      chk_bit(peer_shut, m == 2);
      if (m == 1) begin
        wait_for(0, 1'b1, 2 * RBASE + ONDLY + 12, n);
        chk_range(n, 2 * RBASE - 6, 2 * RBASE + ONDLY + 12);
      end else begin
        cyc(300);
        chk_bit(driver_en, 1'b0);
        pulse(P_CLR);
        chk_bit(fault_status.ov, 1'b0);
      end
    end
    // Over-temperature: default shutdown, then retry with hysteresis
    for (int r = 0; r < 2; r++) begin
      do_reset();
      if (r == 1) begin
        set_cfg(mk_cfg(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, 2'h0));
      end
      power_on();
      tlm.temp <= OT_FAULT_DEF;
      cyc(6);
      chk_bit(driver_en, 1'b1);
      tlm.temp <= OT_FAULT_DEF + 12'h001;
      wait_for(0, 1'b0, 5, n);
      chk_bit(fault_status.ot, 1'b1);
      tlm.temp <= OT_WARN_DEF;
      cyc(3 * RBASE);
      chk_bit(driver_en, 1'b0);
      tlm.temp <= OT_WARN_DEF - 12'h001;
      if (r == 1) begin
        wait_for(0, 1'b1, RBASE + ONDLY + 12, n);
      end else begin
        cyc(300);
        chk_bit(driver_en, 1'b0);
      end
    end
    // Follower shuts down on a peer fault
    do_reset();
    set_cfg(mk_cfg(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 2'h0));
    power_on();
    peer_fault <= 1'b1;
    wait_for(0, 1'b0, 6, n);
    chk_bit(fault_status.group, 1'b1);
    // Stored image survives reset; restore only to an open level
    set_cfg(mk_cfg(1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 2'h0));
    pulse(P_STORE);
    do_reset();
    pulse(P_TICK);
    chk_code({8'h00, phase_a}, 12'h005);
    level_open <= 2'b10;
    pulse(P_RESTORE);
    pulse(P_TICK);
    chk_code({8'h00, phase_a}, 12'h005);
    level_open <= 2'b01;
    pulse(P_RESTORE);
    pulse(P_TICK);
    chk_code({8'h00, phase_a}, 12'h000);
    // Restore to the open user level brings the stored image back
    level_open <= 2'b10;
    restore_level <= 1'b1;
    pulse(P_RESTORE);
    pulse(P_TICK);
    chk_code({8'h00, phase_a}, 12'h005);
    tally_and_finish();
  end
endmodule : ofs_supervisor_tb
